// ---- gain_and_pulse_source_config.sv ----
// Operation
// - Phase-current gain in bits 2:0; codes 0-4 give gain 1-16; resets 000.
// - Phase-current gain codes 101-111 act as unity gain.
// - Neutral-current gain in bits 5:3, same encoding, resets 000.
// - Neutral-current gain codes 101-111 act as unity gain.
// - Without a neutral channel the neutral gain field stays 000.
// - Phase-voltage gain in bits 8:6, same encoding, resets 000.
// - Phase-voltage gain codes 101-111 act as unity gain.
// - Gain bits 15:9 reset to zero and affect nothing.
// - Pulse one source in bits 2:0, resets 000, picks summed power quantity.
// - Pulse one source codes 101-111 stop pulse one generation.
// - Pulse two source in bits 5:3, same encoding, resets 001.
// - Pulse two source codes 101-111 stop pulse two generation.
// - Pulse three source in bits 8:6, same encoding, resets 010.
// - Pulse three source codes 101-111 stop pulse three generation.
// - Bit 9 resets to 1 and gates pulse one pin; converter keeps running.
// - Quantities missing from the variant leave that pulse output idle.
// - Each pulse has a three-bit phase mask, reset all ones, selecting summed phases.
//
// Implementation choice: the Avalon-MM slave port.
module gain_and_pulse_source_config
  import meter_cfg_pkg::*;
#(
  parameter bit HAS_NEUTRAL = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1,
  parameter bit HAS_FUNDAMENTAL = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire phase_power_t [NUM_PHASES-1:0] phase_power_i,
  input wire logic [NUM_PULSE-1:0] pulse_raw_i,
  output gain_sel_t phase_current_gain_o,
  output gain_sel_t neutral_current_gain_o,
  output gain_sel_t phase_voltage_gain_o,
  output pulse_cfg_t [NUM_PULSE-1:0] pulse_cfg_o,
  output logic signed [SUM_W-1:0] pulse_sum_o [NUM_PULSE],
  output logic pulse_output_one_o,
  output logic pulse_output_two_o,
  output logic pulse_output_three_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [REG_W-1:0] merge_write(
    input logic [REG_W-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [3:0] be,
    input logic [REG_W-1:0] wmask
  );
    logic [REG_W-1:0] merged;
    merged = old_val;
    if (be[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      merged[15:8] = wdata[15:8];
    end
    merge_write = merged & wmask;
  endfunction : merge_write

  function automatic logic signed [POWER_W-1:0] pick_power(
    input phase_power_t pw,
    input pulse_source_t src
  );
    case (src)
      SRC_TOTAL_ACTIVE: pick_power = pw.active;
      SRC_TOTAL_REACTIVE: pick_power = pw.reactive;
      SRC_APPARENT: pick_power = pw.apparent;
      SRC_FUND_ACTIVE: pick_power = pw.fund_active;
      SRC_FUND_REACTIVE: pick_power = pw.fund_reactive;
      default: pick_power = pw.active;
    endcase
  endfunction : pick_power

  // ****************************************
  // Registers and bus state
  // ****************************************
  bus_state_t state_r;
  bus_state_t state_nxt;
  logic [REG_W-1:0] incl_r;
  logic [REG_W-1:0] gain_r;
  logic [REG_W-1:0] mode_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // ****************************************
  // Address decode
  // ****************************************
  wire req = avs_read_i | avs_write_i;
  wire hit_incl = (avs_address_i == PHASE_INCLUSION_MODE_ADDR);
  wire hit_gain = (avs_address_i == CHANNEL_GAIN_SELECT_ADDR);
  wire hit_mode = (avs_address_i == PULSE_OUTPUT_MODE_ADDR);
  wire commit = (state_r == BUS_ANSWER) && avs_write_i;
  wire [REG_W-1:0] gain_wmask = HAS_NEUTRAL ? CHANNEL_GAIN_WMASK
                                            : (CHANNEL_GAIN_WMASK & ~NEUTRAL_GAIN_MASK);
  wire [REG_W-1:0] read_val = hit_incl ? incl_r :
                              hit_gain ? gain_r :
                              hit_mode ? mode_r : '0;

  // Upper half of every word reads as zero
  assign rdata_nxt = (state_r == BUS_IDLE && avs_read_i) ? {16'h0000, read_val} : rdata_r;
  assign avs_waitrequest_o = req && (state_r == BUS_IDLE);
  assign avs_readdata_o = rdata_r;

  // ****************************************
  // Bus handshake state
  // ****************************************
  always_comb begin
    case (state_r)
      BUS_IDLE: state_nxt = req ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: state_nxt = BUS_IDLE;
      default: state_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= BUS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Writes land at the edge where waitrequest is sampled low
  logic [REG_W-1:0] incl_nxt;
  logic [REG_W-1:0] gain_nxt;
  logic [REG_W-1:0] mode_nxt;
  logic wr_incl;
  logic wr_gain;
  logic wr_mode;

  assign wr_incl = commit && hit_incl;
  assign wr_gain = commit && hit_gain;
  assign wr_mode = commit && hit_mode;
  assign incl_nxt = wr_incl ? merge_write(incl_r, avs_writedata_i, avs_byteenable_i,
                                          PHASE_INCLUSION_WMASK) : incl_r;
  assign gain_nxt = wr_gain ? merge_write(gain_r, avs_writedata_i, avs_byteenable_i,
                                          gain_wmask) : gain_r;
  assign mode_nxt = wr_mode ? merge_write(mode_r, avs_writedata_i, avs_byteenable_i,
                                          PULSE_OUTPUT_MODE_WMASK) : mode_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      incl_r <= PHASE_INCLUSION_RESET;
    end else begin
      incl_r <= incl_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_r <= CHANNEL_GAIN_RESET;
    end else begin
      gain_r <= gain_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r <= PULSE_OUTPUT_MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  gain_sel_t gain_dec [NUM_FIELDS];
  logic [NUM_PULSE-1:0] run_dec;
  pulse_source_t src_dec [NUM_PULSE];
  pulse_cfg_t [NUM_PULSE-1:0] cfg_dec;

  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g++) begin : g_field
      gain_field_decode u_gain (
        .code_i(gain_r[g*FIELD_W +: FIELD_W]),
        .gain_o(gain_dec[g])
      );

      pulse_source_decode #(
        .HAS_REACTIVE(HAS_REACTIVE),
        .HAS_FUNDAMENTAL(HAS_FUNDAMENTAL)
      ) u_src (
        .sel_i(mode_r[g*FIELD_W +: FIELD_W]),
        .run_o(run_dec[g]),
        .source_o(src_dec[g])
      );

      assign cfg_dec[g].run = run_dec[g];
      assign cfg_dec[g].source = src_dec[g];
      assign cfg_dec[g].mask = incl_r[g*FIELD_W +: NUM_PHASES];
    end
  endgenerate

  // ****************************************
  // Phase summing per pulse output
  // ****************************************
  logic signed [SUM_W-1:0] term [NUM_PULSE][NUM_PHASES];
  logic signed [SUM_W-1:0] sum_nxt [NUM_PULSE];

  genvar c;
  genvar p;
  generate
    for (c = 0; c < NUM_PULSE; c++) begin : g_sum
      for (p = 0; p < NUM_PHASES; p++) begin : g_term
        logic signed [POWER_W-1:0] picked;
        assign picked = pick_power(phase_power_i[p], cfg_dec[c].source);
        assign term[c][p] = cfg_dec[c].mask[p] ? {{(SUM_W-POWER_W){picked[POWER_W-1]}}, picked}
                                               : '0;
      end
      assign sum_nxt[c] = cfg_dec[c].run ? (term[c][0] + term[c][1] + term[c][2])
                                         : '0;
    end
  endgenerate

  // ****************************************
  // Gain outputs
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_current_gain_o <= '0;
      neutral_current_gain_o <= '0;
      phase_voltage_gain_o <= '0;
    end else begin
      phase_current_gain_o <= gain_dec[0];
      neutral_current_gain_o <= gain_dec[1];
      phase_voltage_gain_o <= gain_dec[2];
    end
  end

  // ****************************************
  // Pulse configuration outputs
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_cfg_o <= '0;
    end else begin
      pulse_cfg_o <= cfg_dec;
    end
  end

  // ****************************************
  // Pulse pins
  // ****************************************
  // Pin one is gated here only; its sum below keeps running
  logic pin1_enable;
  logic [NUM_PULSE-1:0] pin_gate;
  logic [NUM_PULSE-1:0] pin_nxt;

  assign pin1_enable = ~mode_r[PULSE1_DIS_BIT];
  assign pin_gate = {run_dec[2], run_dec[1], run_dec[0] & pin1_enable};
  assign pin_nxt = pulse_raw_i & pin_gate;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_output_one_o <= 1'b0;
      pulse_output_two_o <= 1'b0;
      pulse_output_three_o <= 1'b0;
    end else begin
      pulse_output_one_o <= pin_nxt[0];
      pulse_output_two_o <= pin_nxt[1];
      pulse_output_three_o <= pin_nxt[2];
    end
  end

  // ****************************************
  // Converter sums
  // ****************************************
  // Converter sums keep running while the pulse one pin is gated
  generate
    for (c = 0; c < NUM_PULSE; c++) begin : g_sum_reg
      always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pulse_sum_o[c] <= '0;
        end else begin
          pulse_sum_o[c] <= sum_nxt[c];
        end
      end
    end
  endgenerate

endmodule : gain_and_pulse_source_config

// ---- gain_and_pulse_source_config_properties.sv ----
module cfg_properties
  import meter_cfg_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic avs_read_i,
  input wire logic avs_waitrequest_o,
  input wire logic [DATA_W-1:0] avs_readdata_o,
  input wire logic [NUM_PULSE-1:0] pulse_raw_i,
  input wire gain_sel_t phase_current_gain_o,
  input wire gain_sel_t neutral_current_gain_o,
  input wire gain_sel_t phase_voltage_gain_o,
  input wire pulse_cfg_t [NUM_PULSE-1:0] pulse_cfg_o,
  input wire logic signed [SUM_W-1:0] pulse_sum_o [NUM_PULSE],
  input wire logic pulse_output_one_o,
  input wire logic pulse_output_two_o,
  input wire logic pulse_output_three_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Decoded outputs are valid one edge after reset release
  logic up_r;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up_r <= 1'b0;
    end else begin
      up_r <= 1'b1;
    end
  end
  AST_PC_GAIN: assert property (up_r |-> phase_current_gain_o.code <= 3'h4 &&
    phase_current_gain_o.factor == 5'h1 << phase_current_gain_o.code)
    else $error("phase current gain decode wrong");
  AST_NG_GAIN: assert property (up_r |-> neutral_current_gain_o.code <= 3'h4 &&
    neutral_current_gain_o.factor == 5'h1 << neutral_current_gain_o.code)
    else $error("neutral current gain decode wrong");
  AST_PV_GAIN: assert property (up_r |-> phase_voltage_gain_o.code <= 3'h4 &&
    phase_voltage_gain_o.factor == 5'h1 << phase_voltage_gain_o.code)
    else $error("phase voltage gain decode wrong");
  AST_PIN_ONE: assert property (pulse_output_one_o |->
    $past(pulse_raw_i[0]) && pulse_cfg_o[0].run) else $error("pulse one pin without cause");
  AST_PIN_TWO: assert property (pulse_output_two_o |->
    $past(pulse_raw_i[1]) && pulse_cfg_o[1].run) else $error("pulse two pin without cause");
  AST_PIN_THREE: assert property (pulse_output_three_o |->
    $past(pulse_raw_i[2]) && pulse_cfg_o[2].run) else $error("pulse three pin without cause");
  AST_SUM_IDLE: assert property (!pulse_cfg_o[0].run |-> pulse_sum_o[0] == 0)
    else $error("stopped pulse one sum not zero");
  AST_WAIT_ONE: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait longer than one cycle");
  AST_READ_HIGH: assert property (avs_read_i && !avs_waitrequest_o |->
    avs_readdata_o[31:16] == 16'h0) else $error("upper read data not zero");
  cover property (pulse_output_one_o);
  cover property (!pulse_cfg_o[2].run);
  cover property (avs_read_i && !avs_waitrequest_o);
endmodule : cfg_properties

// ---- gain_field_decode.sv ----
module gain_field_decode
  import meter_cfg_pkg::*;
(
  input wire logic [FIELD_W-1:0] code_i,
  output gain_sel_t gain_o
);

  // ****************************************
  // Reserved codes fold onto unity gain
  // ****************************************
  logic [FIELD_W-1:0] eff_code;

  assign eff_code = is_reserved_code(code_i) ? CODE_UNITY : code_i;
  assign gain_o.code = eff_code;
  assign gain_o.factor = GAIN_FACTOR_W'(5'h01 << eff_code);

endmodule : gain_field_decode

// ---- meter_cfg_pkg.sv ----
package meter_cfg_pkg;

  // ****************************************
  // Bus and register geometry
  // ****************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] PHASE_INCLUSION_MODE_IDX = 16'he60e;
  localparam logic [15:0] CHANNEL_GAIN_SELECT_IDX = 16'he60f;
  localparam logic [15:0] PULSE_OUTPUT_MODE_IDX = 16'he610;
  localparam logic [ADDR_W-1:0] PHASE_INCLUSION_MODE_ADDR = {PHASE_INCLUSION_MODE_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CHANNEL_GAIN_SELECT_ADDR = {CHANNEL_GAIN_SELECT_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] PULSE_OUTPUT_MODE_ADDR = {PULSE_OUTPUT_MODE_IDX, 2'b00};

  // ****************************************
  // Field layout
  // ****************************************
  localparam int FIELD_W = 3;
  localparam int NUM_FIELDS = 3;
  localparam int NUM_PHASES = 3;
  localparam int NUM_PULSE = 3;
  localparam int PULSE1_DIS_BIT = 9;
  localparam logic [FIELD_W-1:0] CODE_MAX_VALID = 3'h4;
  localparam logic [FIELD_W-1:0] CODE_UNITY = 3'h0;

  // ****************************************
  // Reset values and writable bits
  // ****************************************
  localparam logic [REG_W-1:0] PHASE_INCLUSION_RESET = 16'h01ff;
  localparam logic [REG_W-1:0] CHANNEL_GAIN_RESET = 16'h0000;
  localparam logic [REG_W-1:0] PULSE_OUTPUT_MODE_RESET = 16'h0288;
  localparam logic [REG_W-1:0] PHASE_INCLUSION_WMASK = 16'h7fff;
  localparam logic [REG_W-1:0] CHANNEL_GAIN_WMASK = 16'h01ff;
  localparam logic [REG_W-1:0] NEUTRAL_GAIN_MASK = 16'h0038;
  localparam logic [REG_W-1:0] PULSE_OUTPUT_MODE_WMASK = 16'h03ff;

  // ****************************************
  // Datapath widths
  // ****************************************
  localparam int POWER_W = 24;
  localparam int SUM_W = 26;
  localparam int GAIN_FACTOR_W = 5;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SRC_TOTAL_ACTIVE,
    SRC_TOTAL_REACTIVE,
    SRC_APPARENT,
    SRC_FUND_ACTIVE,
    SRC_FUND_REACTIVE
  } pulse_source_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;

  typedef struct packed {
    logic signed [POWER_W-1:0] active;
    logic signed [POWER_W-1:0] reactive;
    logic signed [POWER_W-1:0] apparent;
    logic signed [POWER_W-1:0] fund_active;
    logic signed [POWER_W-1:0] fund_reactive;
  } phase_power_t;

  typedef struct packed {
    logic run;
    pulse_source_t source;
    logic [NUM_PHASES-1:0] mask;
  } pulse_cfg_t;

  typedef struct packed {
    logic [FIELD_W-1:0] code;
    logic [GAIN_FACTOR_W-1:0] factor;
  } gain_sel_t;

  function automatic logic is_reserved_code(input logic [FIELD_W-1:0] code);
    is_reserved_code = (code > CODE_MAX_VALID);
  endfunction : is_reserved_code

endpackage : meter_cfg_pkg

// ---- pulse_source_decode.sv ----
module pulse_source_decode
  import meter_cfg_pkg::*;
#(
  parameter bit HAS_REACTIVE = 1'b1,
  parameter bit HAS_FUNDAMENTAL = 1'b1
) (
  input wire logic [FIELD_W-1:0] sel_i,
  output logic run_o,
  output pulse_source_t source_o
);

  // ****************************************
  // Source code decode and variant gating
  // ****************************************
  logic lacks_quantity;

  assign lacks_quantity = (!HAS_REACTIVE && sel_i == 3'h1) ||
                          (!HAS_FUNDAMENTAL && (sel_i == 3'h3 || sel_i == 3'h4));
  assign run_o = !is_reserved_code(sel_i) && !lacks_quantity;
  assign source_o = is_reserved_code(sel_i) ? SRC_TOTAL_ACTIVE : pulse_source_t'(sel_i);

endmodule : pulse_source_decode

// ---- testbench.sv ----
module testbench
  import meter_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [DATA_W-1:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'h3;
  logic [DATA_W-1:0] avs_readdata_o;
  logic avs_waitrequest_o;
  phase_power_t [NUM_PHASES-1:0] phase_power_i;
  logic [NUM_PULSE-1:0] pulse_raw_i = 3'h0;
  gain_sel_t phase_current_gain_o, neutral_current_gain_o, phase_voltage_gain_o;
  pulse_cfg_t [NUM_PULSE-1:0] pulse_cfg_o;
  logic signed [SUM_W-1:0] pulse_sum_o [NUM_PULSE];
  logic [NUM_PULSE-1:0] pins;
  logic [2:0] mk [3] = '{3'h5, 3'h6, 3'h3};
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] rd_v;
  logic [DATA_W-1:0] readdata_v;
  gain_sel_t ng_v;
  pulse_cfg_t [NUM_PULSE-1:0] cfg_v;
  logic [NUM_PULSE-1:0] pins_v;
  int errors = 0;
  int n_tests = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  gain_and_pulse_source_config i_gain_and_pulse_source_config (
    .sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .phase_power_i, .pulse_raw_i,
    .phase_current_gain_o, .neutral_current_gain_o, .phase_voltage_gain_o, .pulse_cfg_o,
    .pulse_sum_o, .pulse_output_one_o(pins[0]), .pulse_output_two_o(pins[1]),
    .pulse_output_three_o(pins[2]));

  // Variant without neutral, reactive and fundamental measurement
  gain_and_pulse_source_config #(
    .HAS_NEUTRAL(1'b0), .HAS_REACTIVE(1'b0), .HAS_FUNDAMENTAL(1'b0)
  ) i_gain_and_pulse_source_config_lean (
    .sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o(readdata_v), .avs_waitrequest_o(), .phase_power_i,
    .pulse_raw_i, .phase_current_gain_o(), .neutral_current_gain_o(ng_v),
    .phase_voltage_gain_o(), .pulse_cfg_o(cfg_v), .pulse_sum_o(),
    .pulse_output_one_o(pins_v[0]), .pulse_output_two_o(pins_v[1]),
    .pulse_output_three_o(pins_v[2]));

  // ****************************************
  // Helpers
  // ****************************************
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [15:0] d,
           input logic [3:0] be);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {16'h0, d};
    avs_byteenable_i <= be;
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    rd_v = readdata_v;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0, 4'h3);
    chk(what, exp, rd);
  endtask : rdchk

  function automatic logic [31:0] exp_sum(input int c, input logic [2:0] m);
    return (c + 1) * (m[0] + 16 * m[1] + 256 * m[2]);
  endfunction : exp_sum

  task chk_pulse(input int k, input logic run, input logic [2:0] m, input logic [31:0] s,
                 input int c);
    chk("pulse run", {31'h0, run}, {31'h0, pulse_cfg_o[k].run});
    chk("pulse source", run ? 32'(c) : 32'h0, {29'h0, pulse_cfg_o[k].source});
    chk("pulse mask", {29'h0, m}, {29'h0, pulse_cfg_o[k].mask});
    chk("pulse sum", run ? s : 32'h0, 32'(pulse_sum_o[k]));
  endtask : chk_pulse

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    rdchk("inclusion", PHASE_INCLUSION_MODE_ADDR, 32'h01ff);
    rdchk("gain reg", CHANNEL_GAIN_SELECT_ADDR, 32'h0);
    rdchk("mode reg", PULSE_OUTPUT_MODE_ADDR, 32'h0288);
    chk("pc gain", 32'h01, {24'h0, phase_current_gain_o});
    chk("ng gain", 32'h01, {24'h0, neutral_current_gain_o});
    chk("pv gain", 32'h01, {24'h0, phase_voltage_gain_o});
    for (int k = 0; k < 3; k++) begin
      chk_pulse(k, 1'b1, 3'h7, exp_sum(k, 3'h7), k);
    end
  endtask : t_reset

  task t_gain;
    logic [2:0] e;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, CHANNEL_GAIN_SELECT_ADDR, 16'hfe00 | {7'h0, 3'(c), 3'(c), 3'(c)}, 4'h3);
      rdchk("gain rb", CHANNEL_GAIN_SELECT_ADDR, {23'h0, 3'(c), 3'(c), 3'(c)});
      chk("lean gain rb", {23'h0, 3'(c), 3'h0, 3'(c)}, rd_v);
      chk("lean ng gain", 32'h01, {24'h0, ng_v});
      e = (c > 4) ? 3'h0 : 3'(c);
      chk("pc gain", {24'h0, e, 5'(5'h1 << e)}, {24'h0, phase_current_gain_o});
      chk("ng gain", {24'h0, e, 5'(5'h1 << e)}, {24'h0, neutral_current_gain_o});
      chk("pv gain", {24'h0, e, 5'(5'h1 << e)}, {24'h0, phase_voltage_gain_o});
    end
    bus(1'b1, CHANNEL_GAIN_SELECT_ADDR, 16'h0, 4'h1);
    rdchk("gain lane", CHANNEL_GAIN_SELECT_ADDR, 32'h0100);
    chk("pv gain", 32'h90, {24'h0, phase_voltage_gain_o});
  endtask : t_gain

  task t_source;
    logic run;
    logic run_v;
    bus(1'b1, PHASE_INCLUSION_MODE_ADDR, 16'h00f5, 4'h3);
    pulse_raw_i <= 3'h7;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, PULSE_OUTPUT_MODE_ADDR, {7'h0, 3'(c), 3'(c), 3'(c)}, 4'h3);
      rdchk("mode rb", PULSE_OUTPUT_MODE_ADDR, {23'h0, 3'(c), 3'(c), 3'(c)});
      repeat (2) @(posedge sys_clk_i);
      run = (c <= 4);
      run_v = (c == 0 || c == 2);
      for (int k = 0; k < 3; k++) begin
        chk_pulse(k, run, mk[k], exp_sum(c, mk[k]), c);
        chk("lean run", {31'h0, run_v}, {31'h0, cfg_v[k].run});
      end
      chk("pins", {29'h0, {3{run}}}, {29'h0, pins});
      chk("lean pins", {29'h0, {3{run_v}}}, {29'h0, pins_v});
    end
    bus(1'b1, PULSE_OUTPUT_MODE_ADDR, 16'hfe00, 4'h3);
    rdchk("mode rb", PULSE_OUTPUT_MODE_ADDR, 32'h0200);
    repeat (2) @(posedge sys_clk_i);
    chk("pins", 32'h6, {29'h0, pins});
    chk_pulse(0, 1'b1, mk[0], exp_sum(0, mk[0]), 0);
    pulse_raw_i <= 3'h0;
    repeat (2) @(posedge sys_clk_i);
    chk("pins", 32'h0, {29'h0, pins});
    bus(1'b1, '0, 16'hffff, 4'h3);
    rdchk("unmapped", '0, 32'h0);
    rdchk("mode rb", PULSE_OUTPUT_MODE_ADDR, 32'h0200);
  endtask : t_source

  task tally_and_finish;
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    logic [23:0] u;
    for (int p = 0; p < 3; p++) begin
      u = 24'h1 << (4 * p);
      phase_power_i[p] = {u, 24'(u * 2), 24'(u * 3), 24'(u * 4), 24'(u * 5)};
    end
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_gain();
    t_source();
    tally_and_finish();
  end

  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end
endmodule : testbench

bind gain_and_pulse_source_config cfg_properties i_cfg_properties (
  .sys_clk_i, .reset_n_i, .avs_read_i, .avs_waitrequest_o, .avs_readdata_o, .pulse_raw_i,
  .phase_current_gain_o, .neutral_current_gain_o, .phase_voltage_gain_o, .pulse_cfg_o,
  .pulse_sum_o, .pulse_output_one_o, .pulse_output_two_o, .pulse_output_three_o);
